// ### design/sdrc_pkg.sv
package sdrc_pkg;
  // ==========================================================
  // Mode word layout
  localparam int MODE_BL_LSB    = 0;
  localparam int MODE_BT_BIT    = 3;
  localparam int MODE_RL_LSB    = 4;
  localparam int MODE_OP_LO_BIT = 7;
  localparam int MODE_OP_HI_BIT = 8;
  localparam int MODE_WB_BIT    = 9;
  localparam logic [2:0] BL_FULL_PAGE = 3'h7;
  // ==========================================================
  // Timing, ns and clocks
  localparam int CLK_PERIOD_NS    = 10;
  localparam int CLK_MHZ          = 100;
  localparam int MAX_MHZ_RL2      = 133;
  localparam int MAX_MHZ_RL3_FAST = 166;
  localparam int MAX_MHZ_RL3_SLOW = 143;
  localparam int T_RCD_NS         = 18;
  localparam int T_RC_NS          = 60;
  localparam int T_RRD_NS         = 12;
  localparam int T_RP_NS          = 18;
  localparam int T_MRD_CLK        = 2;
  localparam int RCD_CLK = (T_RCD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RC_CLK  = (T_RC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RRD_CLK = (T_RRD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RP_CLK  = (T_RP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // ==========================================================
  // Command encodings {cs_n, ras_n, cas_n, we_n}
  localparam logic [3:0] CMD_NOP  = 4'h7;
  localparam logic [3:0] CMD_ACT  = 4'h3;
  localparam logic [3:0] CMD_RD   = 4'h5;
  localparam logic [3:0] CMD_PRE  = 4'h2;
  localparam logic [3:0] CMD_BST  = 4'h6;
  localparam logic [3:0] CMD_MRS  = 4'h0;
  localparam int AP_BIT    = 10;
  localparam int FIFO_DEPTH = 16;
  localparam int DATA_W     = 16;
  // ==========================================================
  // User operations
  localparam logic [1:0] OP_LOAD_MODE = 2'h0;
  localparam logic [1:0] OP_READ      = 2'h1;
  localparam logic [1:0] OP_PRECHARGE = 2'h2;
  typedef enum logic [2:0] {
    ST_IDLE, ST_ACT, ST_WAIT_RCD, ST_READ, ST_STREAM, ST_STOP, ST_MRS
  } sdrc_state_t;
endpackage

// ### design/sdrc_fifo.sv
`timescale 1ns/1ps
module sdrc_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o,
  output logic [$clog2(DEPTH):0] level_o
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  wire push = in_valid_i && in_ready_o;
  wire pop  = out_valid_o && out_ready_i;
  assign in_ready_o  = (count != AW'(0) + (AW+1)'(DEPTH)) ? 1'b1 : 1'b0;
  assign out_valid_o = (count != '0);
  assign out_data_o  = mem[rd_ptr];
  assign level_o     = count;
  always_ff @(posedge clk_i) begin
    if (push) mem[wr_ptr] <= in_data_i;
  end
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) wr_ptr <= wr_ptr + AW'(1);
      if (pop) rd_ptr <= rd_ptr + AW'(1);
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// ### design/sdrc_ctrl.sv
`timescale 1ns/1ps
// Behaviour
// - Operating-mode bits always written as zero
// - Clock rate checked against latency limit
// - Activate opens row before any read
// - Read waits activate-to-access clocks
// - Precharge before new row; row-cycle spacing
// - Bank-to-bank activate spacing kept
// - Read ended latency-minus-one before last
// - No write issued; bus never driven
// - Mask raised three clocks before writes
// - Mask high before truncating write
// - Mask dropped before write data
// - Precharge ends read at latency-minus-one
// - Precharge recovery before next bank command
// - Burst terminate at latency-minus-one
// - Read latency two or three
module sdrc_ctrl (
  input  wire logic        CLK_I,
  input  wire logic        RST_N_I,
  input  wire logic        REQ_VALID_I,
  output logic             REQ_READY_O,
  input  wire logic [1:0]  REQ_OP_I,
  input  wire logic [1:0]  REQ_BANK_I,
  input  wire logic [11:0] REQ_ROW_I,
  input  wire logic [7:0]  REQ_COL_I,
  input  wire logic [8:0]  REQ_LEN_I,
  input  wire logic        REQ_AUTO_PRE_I,
  input  wire logic [2:0]  CFG_BURST_LEN_I,
  input  wire logic        CFG_BURST_TYPE_I,
  input  wire logic [2:0]  CFG_READ_LAT_I,
  input  wire logic        CFG_WRITE_BURST_MODE_I,
  input  wire logic        CFG_FAST_GRADE_I,
  output logic             RD_VALID_O,
  input  wire logic        RD_READY_I,
  output logic [15:0]      RD_DATA_O,
  output logic             CFG_ERR_O,
  output logic             SD_CS_N_O,
  output logic             SD_RAS_N_O,
  output logic             SD_CAS_N_O,
  output logic             SD_WE_N_O,
  output logic [1:0]       SD_BA_O,
  output logic [11:0]      SD_ADDR_O,
  output logic [1:0]       SD_DQM_O,
  input  wire logic [15:0] SD_DQ_I,
  output logic [15:0]      SD_DQ_O,
  output logic             SD_DQ_OE_O
);
  localparam int CW = 4;
  // ==========================================================
  // State and timers
  sdrc_pkg::sdrc_state_t state;
  logic [3:0]  cmd;
  logic [1:0]  ba;
  logic [11:0] addr;
  logic [1:0]  dqm;
  logic [3:0]  open_bank;
  logic [11:0] open_row [4];
  logic [CW-1:0] rcd_cnt [4];
  logic [CW-1:0] rc_cnt  [4];
  logic [CW-1:0] rp_cnt  [4];
  logic [CW-1:0] rrd_cnt;
  logic [CW-1:0] mrd_cnt;
  logic [1:0]  cur_bank;
  logic [7:0]  cur_col;
  logic [8:0]  remain;
  logic        cur_ap;
  logic [1:0]  cur_lat;
  logic [3:0]  cap_pipe;
  logic        fifo_ready;
  logic [4:0]  fifo_level;
  logic [4:0]  inflight;
  // ==========================================================
  // Decode
  wire         lat3     = (CFG_READ_LAT_I == 3'h3);
  wire [7:0]   max_mhz  = lat3 ? (CFG_FAST_GRADE_I ? 8'(sdrc_pkg::MAX_MHZ_RL3_FAST)
                                                  : 8'(sdrc_pkg::MAX_MHZ_RL3_SLOW))
                               : 8'(sdrc_pkg::MAX_MHZ_RL2);
  wire         lat_ok   = (CFG_READ_LAT_I == 3'h2) || lat3;
  wire         rate_ok  = (8'(sdrc_pkg::CLK_MHZ) <= max_mhz);
  wire         cfg_ok   = lat_ok && rate_ok;
  wire         full_pg  = (CFG_BURST_LEN_I == sdrc_pkg::BL_FULL_PAGE);
  wire [8:0]   bl_words = full_pg ? 9'h100 : (9'h1 << CFG_BURST_LEN_I);
  wire         req_rd   = REQ_VALID_I && REQ_READY_O && (REQ_OP_I == sdrc_pkg::OP_READ);
  wire         req_pre  = REQ_VALID_I && REQ_READY_O && (REQ_OP_I == sdrc_pkg::OP_PRECHARGE);
  wire         req_mrs  = REQ_VALID_I && REQ_READY_O && (REQ_OP_I == sdrc_pkg::OP_LOAD_MODE);
  wire         hit      = open_bank[REQ_BANK_I] && (open_row[REQ_BANK_I] == REQ_ROW_I);
  wire         rp_quiet = (rp_cnt[0] == '0) && (rp_cnt[1] == '0)
                          && (rp_cnt[2] == '0) && (rp_cnt[3] == '0);
  wire         act_ok   = (rc_cnt[cur_bank] == '0) && (rrd_cnt == '0)
                          && (rp_cnt[cur_bank] == '0);
  wire         all_idle = (open_bank == 4'h0) && (mrd_cnt == '0) && rp_quiet;
  wire         room     = (5'(fifo_level) + inflight) < 5'(sdrc_pkg::FIFO_DEPTH - 1);
  wire         rd_ok    = (rcd_cnt[cur_bank] == '0) && room;
  wire         rd_issue = rd_ok && (state inside {sdrc_pkg::ST_READ, sdrc_pkg::ST_STREAM});
  wire         last_cmd = (remain == 9'h1);
  wire         cap_now  = cur_lat[0] ? cap_pipe[2] : cap_pipe[1];
  wire [11:0]  mode_word = {2'b00, CFG_WRITE_BURST_MODE_I, 2'b00,
                            CFG_READ_LAT_I, CFG_BURST_TYPE_I, CFG_BURST_LEN_I};
  wire [11:0]  rd_addr  = {1'b0, cur_ap & ~full_pg & last_cmd, 2'b00, cur_col};
  // ==========================================================
  // Command sequencer
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      state    <= sdrc_pkg::ST_IDLE;
      cmd      <= sdrc_pkg::CMD_NOP;
      ba       <= '0;
      addr     <= '0;
      dqm      <= 2'h3;
      open_bank <= '0;
      cur_bank <= '0;
      cur_col  <= '0;
      remain   <= '0;
      cur_ap   <= 1'b0;
      cur_lat  <= 2'h2;
      rrd_cnt  <= '0;
      mrd_cnt  <= '0;
      for (int b = 0; b < 4; b++) begin
        open_row[b] <= '0;
        rcd_cnt[b]  <= '0;
        rc_cnt[b]   <= '0;
        rp_cnt[b]   <= '0;
      end
    end else begin
      cmd <= sdrc_pkg::CMD_NOP;
      dqm <= 2'h0;
      if (rrd_cnt != '0) rrd_cnt <= rrd_cnt - CW'(1);
      if (mrd_cnt != '0) mrd_cnt <= mrd_cnt - CW'(1);
      for (int b = 0; b < 4; b++) begin
        if (rcd_cnt[b] != '0) rcd_cnt[b] <= rcd_cnt[b] - CW'(1);
        if (rc_cnt[b] != '0) rc_cnt[b] <= rc_cnt[b] - CW'(1);
        if (rp_cnt[b] != '0) rp_cnt[b] <= rp_cnt[b] - CW'(1);
      end
      case (state)
        sdrc_pkg::ST_IDLE: begin
          if (req_mrs && cfg_ok && all_idle) begin
            cmd   <= sdrc_pkg::CMD_MRS;
            ba    <= 2'h0;
            addr  <= mode_word;
            cur_lat <= CFG_READ_LAT_I[1:0];
            mrd_cnt <= CW'(sdrc_pkg::T_MRD_CLK);
            state <= sdrc_pkg::ST_MRS;
          end else if (req_pre && open_bank[REQ_BANK_I]) begin
            cmd  <= sdrc_pkg::CMD_PRE;
            ba   <= REQ_BANK_I;
            addr <= '0;
            open_bank[REQ_BANK_I] <= 1'b0;
            rp_cnt[REQ_BANK_I] <= CW'(sdrc_pkg::RP_CLK);
          end else if (req_rd && REQ_LEN_I != '0) begin
            cur_bank <= REQ_BANK_I;
            cur_col  <= REQ_COL_I;
            cur_ap   <= REQ_AUTO_PRE_I;
            remain   <= REQ_LEN_I;
            if (hit) begin
              state <= sdrc_pkg::ST_READ;
            end else if (open_bank[REQ_BANK_I]) begin
              cmd  <= sdrc_pkg::CMD_PRE;
              ba   <= REQ_BANK_I;
              addr <= '0;
              open_bank[REQ_BANK_I] <= 1'b0;
              rp_cnt[REQ_BANK_I] <= CW'(sdrc_pkg::RP_CLK);
              open_row[REQ_BANK_I] <= REQ_ROW_I;
              state <= sdrc_pkg::ST_ACT;
            end else begin
              open_row[REQ_BANK_I] <= REQ_ROW_I;
              state <= sdrc_pkg::ST_ACT;
            end
          end
        end
        sdrc_pkg::ST_ACT: begin
          if (act_ok) begin
            cmd  <= sdrc_pkg::CMD_ACT;
            ba   <= cur_bank;
            addr <= open_row[cur_bank];
            open_bank[cur_bank] <= 1'b1;
            rcd_cnt[cur_bank] <= CW'(sdrc_pkg::RCD_CLK - 1);
            rc_cnt[cur_bank]  <= CW'(sdrc_pkg::RC_CLK - 1);
            rrd_cnt <= CW'(sdrc_pkg::RRD_CLK - 1);
            state <= sdrc_pkg::ST_READ;
          end
        end
        sdrc_pkg::ST_READ, sdrc_pkg::ST_STREAM: begin
          if (rd_ok) begin
            cmd  <= sdrc_pkg::CMD_RD;
            ba   <= cur_bank;
            addr <= rd_addr;
            cur_col <= cur_col + 8'h1;
            remain  <= remain - 9'h1;
            if (last_cmd) begin
              if (cur_ap && !full_pg) begin
                open_bank[cur_bank] <= 1'b0;
                rp_cnt[cur_bank] <= CW'(sdrc_pkg::RP_CLK) + CW'(bl_words);
                state <= sdrc_pkg::ST_IDLE;
              end else begin
                state <= sdrc_pkg::ST_STOP;
              end
            end else begin
              state <= sdrc_pkg::ST_STREAM;
            end
          end
        end
        sdrc_pkg::ST_STOP: begin
          // Stop one clock after the last read, latency-minus-one before last data
          cmd  <= cur_ap ? sdrc_pkg::CMD_PRE : sdrc_pkg::CMD_BST;
          ba   <= cur_bank;
          addr <= '0;
          if (cur_ap) begin
            open_bank[cur_bank] <= 1'b0;
            rp_cnt[cur_bank] <= CW'(sdrc_pkg::RP_CLK);
          end
          state <= sdrc_pkg::ST_IDLE;
        end
        sdrc_pkg::ST_MRS: begin
          if (mrd_cnt == '0) state <= sdrc_pkg::ST_IDLE;
        end
        default: state <= sdrc_pkg::ST_IDLE;
      endcase
    end
  end
  // ==========================================================
  // Read data capture
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      cap_pipe <= '0;
      inflight <= '0;
    end else begin
      cap_pipe <= {cap_pipe[2:0], (cmd == sdrc_pkg::CMD_RD)};
      inflight <= inflight + 5'(rd_issue) - 5'(cap_now);
    end
  end
  sdrc_fifo #(.WIDTH(sdrc_pkg::DATA_W), .DEPTH(sdrc_pkg::FIFO_DEPTH)) u_fifo (
    .clk_i      (CLK_I),
    .rst_n_i    (RST_N_I),
    .in_valid_i (cap_now),
    .in_ready_o (fifo_ready),
    .in_data_i  (SD_DQ_I),
    .out_valid_o(RD_VALID_O),
    .out_ready_i(RD_READY_I),
    .out_data_o (RD_DATA_O),
    .level_o    (fifo_level)
  );
  // ==========================================================
  // Pin registers
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      CFG_ERR_O   <= 1'b0;
      REQ_READY_O <= 1'b0;
    end else begin
      CFG_ERR_O   <= !cfg_ok;
      REQ_READY_O <= (state == sdrc_pkg::ST_IDLE) && !REQ_READY_O && rp_quiet && fifo_ready;
    end
  end
  assign SD_CS_N_O  = cmd[3];
  assign SD_RAS_N_O = cmd[2];
  assign SD_CAS_N_O = cmd[1];
  assign SD_WE_N_O  = cmd[0];
  assign SD_BA_O    = ba;
  assign SD_ADDR_O  = addr;
  assign SD_DQM_O   = dqm;
  assign SD_DQ_O    = '0;
  assign SD_DQ_OE_O = 1'b0;
endmodule

// ### bench/sdrc_dev_model.sv
`timescale 1ns/1ps
// ==========
// Behavioural four-bank memory device
module sdrc_dev_model (
  input  wire logic        clk_i,
  input  wire logic [3:0]  cmd_i,
  input  wire logic [1:0]  ba_i,
  input  wire logic [11:0] addr_i,
  input  wire logic [1:0]  dqm_i,
  output logic      [15:0] dq_o
);
  logic [11:0] mode = 12'h0;
  logic [3:0]  opn  = 4'h0;
  logic [11:0] row [4];
  logic [2:0]  vld  = 3'h0;
  logic [15:0] pipe [3];
  logic [8:0]  left = 9'h0;
  logic [1:0]  cb, m1, m2;
  logic [7:0]  cc, wm;
  logic        ap   = 1'b0;
  int          lat;
  initial dq_o = 16'h0;
  assign lat = (mode[6:4] == 3'h3) ? 3 : 2;
  assign wm  = (mode[2:0] == sdrc_pkg::BL_FULL_PAGE) ? 8'hff : (8'h1 << mode[2:0]) - 8'h1;
  always @(posedge clk_i) begin
    pipe[0] = pipe[1];
    pipe[1] = pipe[2];
    vld = {1'b0, vld[2:1]};
    m2 = m1;
    m1 = dqm_i;
    case (cmd_i)
      sdrc_pkg::CMD_MRS: mode = addr_i;
      sdrc_pkg::CMD_ACT: begin
        opn[ba_i] = 1'b1;
        row[ba_i] = addr_i;
      end
      sdrc_pkg::CMD_BST: left = 9'h0;
      sdrc_pkg::CMD_PRE: begin
        if (addr_i[10]) opn = 4'h0;
        else opn[ba_i] = 1'b0;
        if (addr_i[10] || ba_i == cb) left = 9'h0;
      end
      sdrc_pkg::CMD_RD: if (opn[ba_i]) begin
        cb = ba_i;
        cc = addr_i[7:0];
        ap = addr_i[sdrc_pkg::AP_BIT];
        pipe[lat-1] = {cb, row[cb][5:0], cc};
        vld[lat-1] = 1'b1;
        left = {1'b0, wm};
      end
      default: ;
    endcase
    if (cmd_i != sdrc_pkg::CMD_RD && left != 9'h0) begin
      cc = (cc & ~wm) | ((cc + 8'h1) & wm);
      pipe[lat-1] = {cb, row[cb][5:0], cc};
      vld[lat-1] = 1'b1;
      if (wm != 8'hff) left = left - 9'h1;
    end
    if (ap && left == 9'h0) begin
      opn[cb] = 1'b0;
      ap = 1'b0;
    end
    for (int b = 0; b < 2; b++) begin
      dq_o[8*b +: 8] <= (vld[0] && !m2[b]) ? pipe[0][8*b +: 8] : ~dq_o[8*b +: 8];
    end
  end
endmodule

// ### bench/sdrc_ctrl_assertions.sv
`timescale 1ns/1ps
// ==========
// Command pin checks
module sdrc_ctrl_assertions (
  input wire logic        CLK_I,
  input wire logic        RST_N_I,
  input wire logic [2:0]  CFG_BURST_LEN_I,
  input wire logic        CFG_BURST_TYPE_I,
  input wire logic [2:0]  CFG_READ_LAT_I,
  input wire logic        CFG_WRITE_BURST_MODE_I,
  input wire logic        CFG_ERR_O,
  input wire logic        SD_CS_N_O,
  input wire logic        SD_RAS_N_O,
  input wire logic        SD_CAS_N_O,
  input wire logic        SD_WE_N_O,
  input wire logic [1:0]  SD_BA_O,
  input wire logic [11:0] SD_ADDR_O,
  input wire logic        SD_DQ_OE_O
);
  logic [3:0] c, opn, any;
  logic [3:0] ago [4];
  assign c = {SD_CS_N_O, SD_RAS_N_O, SD_CAS_N_O, SD_WE_N_O};
  wire act  = c == sdrc_pkg::CMD_ACT;
  wire rd   = c == sdrc_pkg::CMD_RD;
  wire pre  = c == sdrc_pkg::CMD_PRE;
  wire idle = SD_CS_N_O || c == sdrc_pkg::CMD_NOP;
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      opn <= 4'h0;
      any <= 4'hf;
      ago <= '{default: 4'hf};
    end else begin
      any <= act ? 4'h1 : any + 4'(any != 4'hf);
      for (int i = 0; i < 4; i++) begin
        ago[i] <= (act && SD_BA_O == 2'(i)) ? 4'h1 : ago[i] + 4'(ago[i] != 4'hf);
      end
      if (act) opn[SD_BA_O] <= 1'b1;
      else if (pre && SD_ADDR_O[10]) opn <= 4'h0;
      else if (pre || (rd && SD_ADDR_O[sdrc_pkg::AP_BIT])) opn[SD_BA_O] <= 1'b0;
    end
  end
  default clocking @(posedge CLK_I); endclocking
  default disable iff (!RST_N_I);
  property p_mode;
    c == sdrc_pkg::CMD_MRS |-> SD_ADDR_O[9:0] == {CFG_WRITE_BURST_MODE_I, 2'h0,
      CFG_READ_LAT_I, CFG_BURST_TYPE_I, CFG_BURST_LEN_I};
  endproperty
  a_mode: assert property (p_mode) else $error("Mode word wrong");
  property p_lat;
    $stable(CFG_READ_LAT_I) |-> CFG_ERR_O == !(CFG_READ_LAT_I inside {3'h2, 3'h3});
  endproperty
  a_lat: assert property (p_lat) else $error("Latency flag wrong");
  property p_open;
    rd |-> opn[SD_BA_O];
  endproperty
  a_open: assert property (p_open) else $error("Read to idle bank");
  property p_rcd;
    rd |-> ago[SD_BA_O] >= sdrc_pkg::RCD_CLK;
  endproperty
  a_rcd: assert property (p_rcd) else $error("Read too soon");
  property p_rc;
    act |-> ago[SD_BA_O] >= sdrc_pkg::RC_CLK && !opn[SD_BA_O];
  endproperty
  a_rc: assert property (p_rc) else $error("Row reopened early");
  property p_rrd;
    act |-> any >= sdrc_pkg::RRD_CLK;
  endproperty
  a_rrd: assert property (p_rrd) else $error("Activates too close");
  property p_rp;
    pre |=> idle || (!$past(SD_ADDR_O[10]) && SD_BA_O != $past(SD_BA_O));
  endproperty
  a_rp: assert property (p_rp) else $error("Bank used in recovery");
  property p_nowr;
    !SD_DQ_OE_O && c != 4'h4;
  endproperty
  a_nowr: assert property (p_nowr) else $error("Data bus driven");
  property p_bst;
    c == sdrc_pkg::CMD_BST |-> $past(rd);
  endproperty
  a_bst: assert property (p_bst) else $error("Terminate not right after read");
  c_mrs: cover property (c == sdrc_pkg::CMD_MRS);
  c_ap: cover property (rd && SD_ADDR_O[10]);
  c_bst: cover property (c == sdrc_pkg::CMD_BST);
endmodule
bind sdrc_ctrl sdrc_ctrl_assertions sdrc_ctrl_assertions_inst (.CLK_I(CLK_I),
  .RST_N_I(RST_N_I), .CFG_BURST_LEN_I(CFG_BURST_LEN_I), .CFG_BURST_TYPE_I(CFG_BURST_TYPE_I),
  .CFG_READ_LAT_I(CFG_READ_LAT_I), .CFG_WRITE_BURST_MODE_I(CFG_WRITE_BURST_MODE_I),
  .CFG_ERR_O(CFG_ERR_O), .SD_CS_N_O(SD_CS_N_O), .SD_RAS_N_O(SD_RAS_N_O),
  .SD_CAS_N_O(SD_CAS_N_O), .SD_WE_N_O(SD_WE_N_O), .SD_BA_O(SD_BA_O),
  .SD_ADDR_O(SD_ADDR_O), .SD_DQ_OE_O(SD_DQ_OE_O));

// ### bench/testbench.sv
`timescale 1ns/1ps
// ==========
// Read controller bench
module testbench;
  logic        clk, rst_n, vld, rdy, ap, rv, rr, err, fast, bt, wbm, cs, ras, cas, we, oe;
  logic [1:0]  op, bk, ba, dqm;
  logic [11:0] row, addr;
  logic [7:0]  col;
  logic [8:0]  len;
  logic [2:0]  bl, rl;
  logic [15:0] rdat, dout, ddev;
  int          failures = 0, n_tests = 0, cycles = 0;
  sdrc_ctrl sdrc_ctrl_inst (.CLK_I(clk), .RST_N_I(rst_n), .REQ_VALID_I(vld),
    .REQ_READY_O(rdy), .REQ_OP_I(op), .REQ_BANK_I(bk), .REQ_ROW_I(row), .REQ_COL_I(col),
    .REQ_LEN_I(len), .REQ_AUTO_PRE_I(ap), .CFG_BURST_LEN_I(bl), .CFG_BURST_TYPE_I(bt),
    .CFG_READ_LAT_I(rl), .CFG_WRITE_BURST_MODE_I(wbm), .CFG_FAST_GRADE_I(fast),
    .RD_VALID_O(rv), .RD_READY_I(rr), .RD_DATA_O(rdat), .CFG_ERR_O(err), .SD_CS_N_O(cs),
    .SD_RAS_N_O(ras), .SD_CAS_N_O(cas), .SD_WE_N_O(we), .SD_BA_O(ba), .SD_ADDR_O(addr),
    .SD_DQM_O(dqm), .SD_DQ_I(oe ? dout : ddev), .SD_DQ_O(dout), .SD_DQ_OE_O(oe));
  sdrc_dev_model sdrc_dev_model_inst (.clk_i(clk), .cmd_i({cs, ras, cas, we}), .ba_i(ba),
    .addr_i(addr), .dqm_i(dqm), .dq_o(ddev));
  always #5 clk = ~clk;
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic results();
    $display("Comparisons %0d, mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic req(input logic [1:0] o, b, input logic [11:0] r, input logic [7:0] c,
                     input logic [8:0] l, input logic a);
    int n;
    @(posedge clk);
    #1 {op, bk, row, col, len, ap, vld} = {o, b, r, c, l, a, 1'b1};
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (rdy !== 1'b1 && n < 300);
    check({15'h0, rdy}, 16'h1);
    #1 vld = 1'b0;
  endtask
  task automatic rd(input logic [1:0] b, input logic [11:0] r, input logic [7:0] c,
                    input logic [8:0] l, input logic a, input logic stall);
    int got, n;
    rr = !stall;
    req(sdrc_pkg::OP_READ, b, r, c, l, a);
    if (stall) begin
      repeat (60) @(posedge clk);
      #1 check({15'h0, rv}, 16'h1);
      rr = 1'b1;
    end
    got = 0;
    n = 0;
    while (got < l && n < 600) begin
      @(posedge clk);
      n++;
      if (rv === 1'b1 && rr) begin
        check(rdat, {b, r[5:0], c + 8'(got)});
        got++;
      end
    end
    check(16'(got), 16'(l));
    repeat (12) @(posedge clk);
    check({15'h0, rv}, 16'h0);
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      results();
    end
  end
  initial begin
    {clk, rst_n, vld, op, bk, row, col, len, ap, bt, wbm, fast} = '0;
    {bl, rl, rr} = {3'h7, 3'h2, 1'b1};
    repeat (20) @(posedge clk);
    #1 rst_n = 1'b1;
    repeat (2) @(posedge clk);
    #1 rl = 3'h1;
    repeat (3) @(posedge clk);
    #1 check({15'h0, err}, 16'h1);
    {rl, fast} = {3'h3, 1'b1};
    repeat (3) @(posedge clk);
    #1 check({15'h0, err}, 16'h0);
    for (int it = 0; it < 2; it++) begin
      {rl, bl, wbm} = {3'h2 + 3'(it), it ? 3'h2 : 3'h7, 1'(it)};
      req(sdrc_pkg::OP_LOAD_MODE, 2'h0, 12'h0, 8'h0, 9'h0, 1'b0);
      rd(2'h0, 12'h005, 8'h10, 9'd4, 1'b0, 1'b0);
      rd(2'h0, 12'h005, 8'hfe, 9'd3, 1'b0, 1'b0);
      rd(2'h1, 12'h009, 8'h00, 9'd2, 1'b1, 1'b0);
      rd(2'h1, 12'h003, 8'h08, 9'd1, 1'b0, 1'b0);
      rd(2'h0, 12'h00a, 8'h30, 9'd2, 1'b0, 1'b0);
      rd(2'h2, 12'h001, 8'h20, 9'd20, 1'b0, 1'b1);
      for (int b = 0; b < 3; b++) begin
        req(sdrc_pkg::OP_PRECHARGE, 2'(b), 12'h0, 8'h0, 9'h0, 1'b0);
      end
      $display("Read pass %0d done", it);
    end
    results();
  end
endmodule
